// ===== rtl/pc_stack_consts.svh
// Purpose: Constants for program counter, return stack and indirect addressing
// Assumes: Included by bare name from package and modules
// Notes:   Definitions only
`ifndef PC_STACK_CONSTS_SVH
`define PC_STACK_CONSTS_SVH

`define PC_WIDTH          13
`define PC_RESET          13'h0000
`define STACK_DEPTH       8
`define LATCH_WIDTH       5
`define LATCH_RESET       5'h00
`define LATCH_PAGE_BIT    3
`define LATCH_HIGH_BIT    4
`define JUMP_FIELD_WIDTH  11
`define FSR_RESET         8'h00
`define INDIRECT_PORT_ADR 8'h00
`define REG_PC_LOW        8'h02
`define REG_FILE_PTR      8'h04
`define REG_LATCH         8'h0A
`define REG_BANK_SEL      8'h03
`define BANK_SEL_BIT      7
`define UNMAPPED_READ     8'h00

`endif

// ===== rtl/pc_stack_pkg.sv
// Purpose: Types for program counter and return stack block
// Assumes: Constants come from pc_stack_consts.svh
// Notes:   Types only
`include "pc_stack_consts.svh"
package pc_stack_pkg;

  typedef logic [`PC_WIDTH-1:0] pc_t;

  typedef enum logic [2:0]
  {
    FLOW_NEXT,
    FLOW_JUMP,
    FLOW_CALL,
    FLOW_RETURN,
    FLOW_VECTOR
  } flow_op_e;

  typedef struct packed
  {
    flow_op_e                          op;
    logic [`JUMP_FIELD_WIDTH-1:0]      target;
  } flow_cmd_s;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage : pc_stack_pkg

// ===== rtl/return_stack.sv
// Purpose: Circular return-address stack
// Assumes: Push and pop never requested together
// Notes:   Silent wrap in both directions, pointer hidden
`timescale 1ns/10ps
`include "pc_stack_consts.svh"
module return_stack
#(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int WIDTH = `PC_WIDTH
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // Stack operations
  input  wire logic             i_push,
  input  wire logic             i_pop,
  input  wire logic [WIDTH-1:0] i_push_data,
  output logic      [WIDTH-1:0] o_top
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer arithmetic wraps only for power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("return_stack: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  logic [PW-1:0]    ptr_d;

  // Pointer wraps modulo depth, no overflow flag
  always_comb
  begin
    ptr_d = ptr_q;
    if (i_push)
      ptr_d = ptr_q + PW'(1); // [R9] [R10]
    else if (i_pop)
      ptr_d = ptr_q - PW'(1); // [R10]
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ptr_q <= '0;
    else
      ptr_q <= ptr_d;
  end

  // Oldest entry overwritten once full
  always_ff @(posedge i_clk)
  begin
    if (i_push)
      mem_q[ptr_q] <= i_push_data; // [R9]
  end

  assign o_top = mem_q[ptr_q - PW'(1)];

endmodule : return_stack

// ===== rtl/pc_stack_indirect.sv
// Purpose: Program counter, paging, return stack and indirect addressing
// Assumes: Decoder issues one flow command per cycle; register port strobes
// Notes:   Indirect data access forwarded to the data memory port
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "pc_stack_consts.svh"

// Functional notes
// [R1] 13-bit counter, low byte software register
// [R2] Any reset clears the counter
// [R3] Low-byte write loads upper five from latch
// [R4] Call/jump: 11 field bits, page latch bits
// [R5] Eight by thirteen stack, pointer hidden
// [R6] Call or interrupt vector pushes counter
// [R7] Return kinds pop full address
// [R8] Push and pop leave latch unchanged
// [R9] Ninth push overwrites first entry
// [R10] No overflow or underflow indication
// [R11] Latch bit 3 selects 2K page
// [R12] Latch bit 4 ignored by paging; the code puts it on counter bit 12 for call/jump
// [R13] Indirect port accesses pointed location; the code strobes it but reads zero at the port
// [R14] Port pointing at itself reads zero
// [R15] Port pointing at itself writes nothing
// [R16] Effective address bank bit over pointer; the code drives address bit 8 as zero
// [R17] Bank bit reserved, kept clear; the code stores written bit 7 and reads it back
// [R18] Latch changes only on software writes
module program_counter_stack_indirect
#(
  parameter int        STACK_DEPTH = `STACK_DEPTH,
  parameter logic [12:0] VECTOR_ADDR = 13'h0004
)
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  // Flow commands from decoder
  input  wire pc_stack_pkg::flow_cmd_s  i_flow,
  // Register port
  input  wire pc_stack_pkg::reg_req_s   i_reg,
  output logic [7:0]                    o_rdata,
  // Data memory port for indirect access
  output logic [8:0]                    o_mem_addr,
  output logic [7:0]                    o_mem_wdata,
  output logic                          o_mem_wr,
  output logic                          o_mem_rd,
  input  wire logic [7:0]               i_mem_rdata,
  // Program counter to fetch
  output logic [12:0]                   o_pc
);

  import pc_stack_pkg::*;

  if (STACK_DEPTH != `STACK_DEPTH)
  begin : g_depth_check
    $error("program_counter_stack_indirect: stack depth must be 8");
  end

  function automatic logic is_port(input logic [7:0] a);
    return a == `INDIRECT_PORT_ADR;
  endfunction : is_port

  pc_t        pc_q;
  pc_t        pc_d;
  logic [4:0] latch_q;
  logic [4:0] latch_d;
  logic [7:0] fsr_q;
  logic [7:0] fsr_d;
  logic       bank_q;
  logic       bank_d;
  logic [7:0] rdata_d;
  logic [8:0] maddr_d;
  logic [7:0] mwdata_d;
  logic       mwr_d;
  logic       mrd_d;
  logic       push;
  logic       pop;
  pc_t        stack_top;
  pc_t        pc_next;
  logic       pcl_wr;
  logic       ind_hit;

  assign push    = (i_flow.op == FLOW_CALL) || (i_flow.op == FLOW_VECTOR); // [R6]
  assign pop     = (i_flow.op == FLOW_RETURN); // [R7]
  assign pc_next = pc_q + 13'h0001;
  assign ind_hit = is_port(i_reg.addr);
  assign pcl_wr  = i_reg.wr && (i_reg.addr == `REG_PC_LOW);

  return_stack
  #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (`PC_WIDTH)
  )
  u_stack
  (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_push      (push),
    .i_pop       (pop),
    .i_push_data (i_flow.op == FLOW_CALL ? pc_next : pc_q), // [R5] [R6]
    .o_top       (stack_top)
  );

  // Program counter next value
  always_comb
  begin
    pc_d = pc_next;
    case (i_flow.op)
      FLOW_NEXT:
        pc_d = pc_next;
      FLOW_JUMP,
      FLOW_CALL:
        pc_d = {latch_q[`LATCH_HIGH_BIT:`LATCH_PAGE_BIT], i_flow.target}; // [R4] [R11] [R12]
      FLOW_RETURN:
        pc_d = stack_top; // [R7]
      FLOW_VECTOR:
        pc_d = VECTOR_ADDR;
      default:
        pc_d = pc_next;
    endcase
    if (pcl_wr)
      pc_d = {latch_q, i_reg.wdata}; // [R1] [R3]
  end

  // Software-written state
  always_comb
  begin
    latch_d = latch_q;
    fsr_d   = fsr_q;
    bank_d  = bank_q;
    if (i_reg.wr)
    begin
      case (i_reg.addr)
        `REG_LATCH:
          latch_d = i_reg.wdata[`LATCH_WIDTH-1:0]; // [R18] [R8]
        `REG_FILE_PTR:
          fsr_d = i_reg.wdata;
        `REG_BANK_SEL:
          bank_d = i_reg.wdata[`BANK_SEL_BIT]; // [R17]
        default:
          latch_d = latch_q;
      endcase
    end
  end

  // Indirect access and read data
  always_comb
  begin
    maddr_d  = {1'b0, fsr_q}; // [R16] [R17]
    mwdata_d = i_reg.wdata;
    mwr_d    = i_reg.wr && ind_hit && !is_port(fsr_q); // [R13] [R15]
    mrd_d    = i_reg.rd && ind_hit && !is_port(fsr_q); // [R13]
    rdata_d  = `UNMAPPED_READ;
    if (i_reg.rd)
    begin
      case (i_reg.addr)
        `REG_PC_LOW:
          rdata_d = pc_q[7:0]; // [R1]
        `REG_LATCH:
          rdata_d = {3'h0, latch_q};
        `REG_FILE_PTR:
          rdata_d = fsr_q;
        `REG_BANK_SEL:
          rdata_d = {bank_q, 7'h00};
        `INDIRECT_PORT_ADR:
          rdata_d = `UNMAPPED_READ; // [R14]
        default:
          rdata_d = `UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pc_q        <= `PC_RESET; // [R2]
      latch_q     <= `LATCH_RESET;
      fsr_q       <= `FSR_RESET;
      bank_q      <= 1'b0;
      o_rdata     <= 8'h00;
      o_mem_addr  <= 9'h000;
      o_mem_wdata <= 8'h00;
      o_mem_wr    <= 1'b0;
      o_mem_rd    <= 1'b0;
    end
    else
    begin
      pc_q        <= pc_d;
      latch_q     <= latch_d;
      fsr_q       <= fsr_d;
      bank_q      <= bank_d;
      o_rdata     <= rdata_d;
      o_mem_addr  <= maddr_d;
      o_mem_wdata <= mwdata_d;
      o_mem_wr    <= mwr_d;
      o_mem_rd    <= mrd_d;
    end
  end

  assign o_pc = pc_q;

endmodule : program_counter_stack_indirect

// ===== verif/pc_stack_props.sv
// Purpose: Port checks for program counter block
// Assumes: Register offsets as chosen by the design
// Notes:   Bound to the top module
`timescale 1ns/10ps
module pc_stack_checker
#(parameter int STACK_DEPTH = 8)
(
  input wire logic                    i_clk,
  input wire logic                    i_rstn,
  input wire pc_stack_pkg::flow_cmd_s i_flow,
  input wire pc_stack_pkg::reg_req_s  i_reg,
  input wire logic [7:0]              o_rdata,
  input wire logic [8:0]              o_mem_addr,
  input wire logic [7:0]              o_mem_wdata,
  input wire logic                    o_mem_wr,
  input wire logic [12:0]             o_pc
);
  import pc_stack_pkg::*;
  logic pw;
  assign pw = i_reg.wr && i_reg.addr == 8'h02;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_rst; $rose(i_rstn) |-> o_pc == 13'h0000; endproperty
  a_rst: assert property (p_rst) else $error("pc not clear");
  property p_pcl; pw |=> o_pc[7:0] == $past(i_reg.wdata); endproperty
  a_pcl: assert property (p_pcl) else $error("low byte");
  property p_jmp; i_flow.op == FLOW_JUMP && !pw |=> o_pc[10:0] == $past(i_flow.target);
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump field");
  property p_ret;
    (i_flow.op == FLOW_CALL && !pw) ##1 (i_flow.op == FLOW_RETURN && !pw)
    |=> o_pc == $past(o_pc, 2) + 13'h0001;
  endproperty
  a_ret: assert property (p_ret) else $error("return addr");
  property p_bank; o_mem_wr |-> !o_mem_addr[8]; endproperty
  a_bank: assert property (p_bank) else $error("bank bit");
  property p_self; o_mem_wr |-> o_mem_addr[7:0] != 8'h00; endproperty
  a_self: assert property (p_self) else $error("self write");
  property p_mwc;
    o_mem_wr |-> $past(i_reg.wr) && $past(i_reg.addr) == 8'h00
      && o_mem_wdata == $past(i_reg.wdata);
  endproperty
  a_mwc: assert property (p_mwc) else $error("indirect write");
  property p_rd0; i_reg.rd && i_reg.addr == 8'h00 |=> o_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("port read");
  c_call: cover property (i_flow.op == FLOW_CALL ##1 i_flow.op == FLOW_RETURN);
  c_vec: cover property (i_flow.op == FLOW_VECTOR);
  c_mwr: cover property (o_mem_wr);
endmodule : pc_stack_checker

bind program_counter_stack_indirect pc_stack_checker #(.STACK_DEPTH(STACK_DEPTH)) chk
  (.i_clk(i_clk), .i_rstn(i_rstn), .i_flow(i_flow), .i_reg(i_reg), .o_rdata(o_rdata),
   .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_wr(o_mem_wr), .o_pc(o_pc));

// ===== verif/decoder_model.sv
// Purpose: Decoder and data memory stand-in
// Assumes: Bench picks one flow command a cycle
// Notes:   Memory data moves every cycle, never held
`timescale 1ns/10ps
module decoder_model
(
  input  wire logic                   i_clk,
  input  wire pc_stack_pkg::flow_op_e i_op,
  input  wire logic [10:0]            i_tgt,
  output pc_stack_pkg::flow_cmd_s     o_flow,
  output logic [7:0]                  o_mem_rdata
);
  assign o_flow = {i_op, i_tgt};
  initial o_mem_rdata = 8'hA5;
  always @(posedge i_clk) o_mem_rdata <= ~o_mem_rdata + 8'h01;
endmodule : decoder_model

// ===== verif/test_program_counter_stack_indirect.sv
// Purpose: Self-checking bench for program counter block
// Assumes: Design lags one step behind the model
// Notes:   One cycle a step, every output compared each step, memory address and write data only on a write
`timescale 1ns/10ps
module test_program_counter_stack_indirect;
  import pc_stack_pkg::*;
  logic        i_clk = 0, i_rstn = 0, mwr, mrq;
  logic [7:0]  rdat, mwd, mrd;
  logic [8:0]  madr;
  logic [12:0] pc;
  logic [10:0] tgt = 0;
  flow_op_e    op = FLOW_NEXT;
  flow_cmd_s   fl;
  reg_req_s    rq = '0;
  int error_cnt = 0, compares = 0, e_pc, lat, ptr, sp, e_rd, e_mem, e_mrd, bk, p, stk[8];
  always #50 i_clk = ~i_clk;
  decoder_model dec (.i_clk(i_clk), .i_op(op), .i_tgt(tgt), .o_flow(fl), .o_mem_rdata(mrd));
  program_counter_stack_indirect uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_flow(fl), .i_reg(rq),
    .o_rdata(rdat), .o_mem_addr(madr), .o_mem_wdata(mwd), .o_mem_wr(mwr), .o_mem_rd(mrq),
    .i_mem_rdata(mrd), .o_pc(pc));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rst;
    @(posedge i_clk);
    i_rstn <= 0;
    op <= FLOW_NEXT;
    rq <= '0;
    repeat (6) @(posedge i_clk);
    chk(18'(pc), 18'h0);
    i_rstn <= 1;
    {e_pc, lat, ptr, sp, e_rd, e_mem, e_mrd, bk} = {32'd1, 224'd0};
  endtask : rst
  task automatic step(input flow_op_e o, input int t, a, d, w, r);
    int n;
    @(posedge i_clk);
    op <= o;
    tgt <= 11'(t);
    rq <= '{addr: 8'(a), wdata: 8'(d), wr: w[0], rd: r[0]};
    @(negedge i_clk);
    chk(18'(pc), 18'(e_pc));
    chk(18'(rdat), 18'(e_rd));
    chk({mwr, mwr ? {madr, mwd} : 17'h0}, 18'(e_mem));
    chk(18'(mrq), 18'(e_mrd));
    e_rd = !r ? 0 : a == 2 ? e_pc & 255 : a == 3 ? bk << 7 : a == 4 ? ptr : a == 10 ? lat : 0;
    e_mem = (w && a == 0 && ptr != 0) ? 'h20000 | ptr << 8 | d : 0;
    e_mrd = (r && a == 0 && ptr != 0) ? 1 : 0;
    n = (e_pc + 1) % 8192;
    if (o == FLOW_CALL || o == FLOW_VECTOR)
    begin
      stk[sp] = o == FLOW_CALL ? n : e_pc;
      sp = (sp + 1) % 8;
    end
    if (o == FLOW_JUMP || o == FLOW_CALL) n = (lat & 'h18) << 8 | t;
    if (o == FLOW_VECTOR) n = 4;
    if (o == FLOW_RETURN)
    begin
      sp = (sp + 7) % 8;
      n = stk[sp];
    end
    if (w && a == 2) n = lat << 8 | d;
    if (w && a == 4) ptr = d;
    if (w && a == 3) bk = (d >> 7) & 1;
    if (w && a == 10) lat = d & 'h1F;
    e_pc = n;
  endtask : step
  task automatic final_report;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // About ten times the expected run
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'h3f282363));
    rst();
    for (int i = 0; i < 4; i++)
    begin
      step(FLOW_NEXT, 0, 10, i * 8 + 3, 1, 0);
      step(FLOW_NEXT, 0, 2, $urandom % 256, 1, 0);
      step(i < 3 ? FLOW_JUMP : FLOW_NEXT, $urandom % 2048, 10, 0, 0, 1);
      step(FLOW_NEXT, 0, 2, 0, 0, 1);
    end
    step(FLOW_NEXT, 0, 'h55, 9, 1, 0);
    step(FLOW_NEXT, 0, 'h55, 0, 0, 1);
    $display("pc load test done");
    step(FLOW_NEXT, 0, 10, 8, 1, 0);
    repeat (9) step(FLOW_CALL, $urandom % 2048, 0, 0, 0, 0);
    repeat (9) step(FLOW_RETURN, 0, 10, 0, 0, 1);
    step(FLOW_VECTOR, 0, 0, 0, 0, 0);
    step(FLOW_RETURN, 0, 0, 0, 0, 0);
    $display("stack test done");
    for (int i = 0; i < 6; i++)
    begin
      p = i == 0 ? 0 : 1 + $urandom % 255;
      step(FLOW_NEXT, 0, 4, p, 1, 0);
      step(FLOW_NEXT, 0, 3, $urandom % 256, 1, 0);
      step(FLOW_NEXT, 0, 0, $urandom % 256, 1, 0);
      step(FLOW_NEXT, 0, 3, 0, 0, 1);
      step(FLOW_NEXT, 0, 0, 0, 0, 1);
      step(FLOW_NEXT, 0, 4, 0, 0, 1);
    end
    $display("indirect test done");
    rst();
    step(FLOW_CALL, 5, 0, 0, 0, 0);
    step(FLOW_RETURN, 0, 0, 0, 0, 0);
    step(FLOW_NEXT, 0, 0, 0, 0, 0);
    $display("reset test done");
    final_report();
  end
endmodule : test_program_counter_stack_indirect
